// ==== rtl/nsdl_core.v ====
// Execution of the nibble-exchange and direction-load instructions
`timescale 1ns/100ps
`include "nsdl_defs.vh"

// Timing overview:
//   An instruction issued on one edge shows its results on the next edge.
//   Direction outputs are flop copies of the inner registers, one edge later.
//   Memory read-back answers the address seen on the previous edge.
//   A same-cycle instruction load and store to one register: the load wins.
//   Status flags are never written here; FLAGS_HOLD tells the core to keep them.

module nsdl_core #(
  parameter DW       = 8,
  parameter IW       = 14,
  parameter AW       = 7,
  parameter DIR_BASE = 7'h05
) (
  // Clock and reset
  input  wire          CLK,
  input  wire          RESETN,
  // Instruction issue
  input  wire          INSTR_VALID,
  input  wire [IW-1:0] INSTR,
  // Operand read from the addressed data register
  input  wire [DW-1:0] FILE_RDATA,
  // Ordinary data-memory access to direction registers
  input  wire          MEM_WE,
  input  wire [AW-1:0] MEM_ADDR,
  input  wire [DW-1:0] MEM_WDATA,
  // Result write-back to data memory
  output reg           FILE_WE,
  output reg  [AW-1:0] FILE_WADDR,
  output reg  [DW-1:0] FILE_WDATA,
  // Accumulator and status
  output reg  [DW-1:0] W_VALUE,
  output reg           FLAGS_HOLD,
  output reg           DONE,
  output reg           ILLEGAL_SEL,
  // Direction registers and memory read-back
  output reg  [DW-1:0] DIR_A,
  output reg  [DW-1:0] DIR_B,
  output reg  [DW-1:0] DIR_C,
  output reg  [DW-1:0] MEM_RDATA,
  output reg           MEM_RHIT
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire          is_nibx;
  wire          is_dirld;
  wire          dest_file;
  wire [2:0]    sel;
  wire          sel_ok;
  wire [DW-1:0] swapped;
  reg  [DW-1:0] w_reg;
  reg  [DW-1:0] w_next;

  // Valid gates both decodes so an idle instruction word does nothing
  assign is_nibx   = INSTR_VALID && (INSTR[`NSDL_OPC_HI:`NSDL_OPC_LO] == `NSDL_OPC_NIBX);
  assign is_dirld  = INSTR_VALID &&
                     (INSTR[`NSDL_DIRLD_WORD_HI:`NSDL_DIRLD_WORD_LO] == `NSDL_DIRLD_PATTERN);
  // Destination bit: zero targets the accumulator, one the source register
  assign dest_file = INSTR[`NSDL_DEST_BIT];
  // Selector field only means something for the direction-load word
  assign sel       = INSTR[`NSDL_SEL_HI:`NSDL_SEL_LO];
  // Selectors below 5 name no register and are dropped
  assign sel_ok    = (sel >= `NSDL_SEL_MIN) && (sel <= `NSDL_SEL_MAX);
  // Upper result half takes low source half and vice versa
  assign swapped   = {FILE_RDATA[DW/2-1:0], FILE_RDATA[DW-1:DW/2]};

  ////////////////////////////////////////////////////////////////////////
  // Direction registers

  wire [DW-1:0] dir_val [0:2];
  wire [2:0]    dir_ins_we;
  wire [2:0]    dir_mem_we;
  wire [AW-1:0] mem_off;
  wire          mem_in_dir;
  reg  [DW-1:0] rd_mux;

  // Offset from the first direction register; low addresses wrap far away
  // so they can never alias onto a direction register
  assign mem_off    = MEM_ADDR - DIR_BASE;
  // Only three direction registers exist above the base
  assign mem_in_dir = (mem_off < 3);

  // One register per selector; each picks its own write source
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_dir
      localparam [2:0]    SEL_CODE = `NSDL_SEL_MIN + gi;
      localparam [AW-1:0] MEM_SLOT = gi;

      // Instruction load aimed at this register only
      assign dir_ins_we[gi] = is_dirld && sel_ok && (sel == SEL_CODE);
      // Ordinary store aimed at this register only
      assign dir_mem_we[gi] = MEM_WE && (mem_off == MEM_SLOT);

      // Load wins on its own register only, so a store to a sibling still lands
      nsdl_dir_reg #(
        .WIDTH (DW)
      ) u_dir (
        .clk    (CLK),
        .resetn (RESETN),
        .ins_we (dir_ins_we[gi]),
        .mem_we (dir_mem_we[gi]),
        .wdata  (dir_ins_we[gi] ? w_reg : MEM_WDATA),
        .value  (dir_val[gi])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read as zero, never a stale register
  always @* begin
    rd_mux = {DW{1'b0}};
    if (mem_in_dir) begin
      rd_mux = dir_val[mem_off[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator next value

  always @* begin
    w_next = w_reg;
    if (is_nibx && !dest_file) begin
      w_next = swapped;
    end
  end

  // Single-cycle completion: no stall state exists, so back-to-back
  // instructions always see the accumulator value of the previous one
  always @(posedge CLK) begin
    if (!RESETN) begin
      w_reg   <= `NSDL_W_RESET;
      W_VALUE <= `NSDL_W_RESET;
    end else begin
      w_reg   <= w_next;
      W_VALUE <= w_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register write-back

  // Address and data follow every cycle; only the strobe makes them count.
  // The core owns the file port, so this block needs no memory of its own.
  always @(posedge CLK) begin
    if (!RESETN) begin
      FILE_WE    <= 1'b0;
      FILE_WADDR <= {AW{1'b0}};
      FILE_WDATA <= {DW{1'b0}};
    end else begin
      FILE_WE    <= is_nibx && dest_file;
      FILE_WADDR <= INSTR[`NSDL_ADDR_HI:`NSDL_ADDR_LO];
      FILE_WDATA <= swapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status pulses

  // Neither instruction touches status; tell the core to keep them
  always @(posedge CLK) begin
    if (!RESETN) begin
      FLAGS_HOLD  <= 1'b0;
      DONE        <= 1'b0;
      ILLEGAL_SEL <= 1'b0;
    end else begin
      FLAGS_HOLD  <= is_nibx || is_dirld;
      // A refused selector still completes; it only skips the write
      DONE        <= is_nibx || is_dirld;
      // Low selectors name no register; flag it for the core
      ILLEGAL_SEL <= is_dirld && !sel_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direction outputs

  // Output copies lag the inner registers by one edge; this keeps every
  // top-level output on a flop at the cost of one cycle of latency
  always @(posedge CLK) begin
    if (!RESETN) begin
      DIR_A <= `NSDL_DIR_RESET;
      DIR_B <= `NSDL_DIR_RESET;
      DIR_C <= `NSDL_DIR_RESET;
    end else begin
      DIR_A <= dir_val[0];
      DIR_B <= dir_val[1];
      DIR_C <= dir_val[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory read-back

  // Read-back answers the address of the previous cycle
  always @(posedge CLK) begin
    if (!RESETN) begin
      MEM_RHIT  <= 1'b0;
      MEM_RDATA <= {DW{1'b0}};
    end else begin
      MEM_RHIT  <= mem_in_dir;
      MEM_RDATA <= rd_mux;
    end
  end

endmodule

// ==== rtl/nsdl_defs.vh ====
// Constants for the nibble-exchange and direction-load execution block
`ifndef NSDL_DEFS_VH
`define NSDL_DEFS_VH

// Opcode fields of the 14-bit instruction word
`define NSDL_OPC_HI         13
`define NSDL_OPC_LO         8
`define NSDL_OPC_NIBX       6'h0E
`define NSDL_DIRLD_WORD_HI  13
`define NSDL_DIRLD_WORD_LO  3
`define NSDL_DIRLD_PATTERN  11'h00C
`define NSDL_DEST_BIT       7
`define NSDL_ADDR_HI        6
`define NSDL_ADDR_LO        0
`define NSDL_SEL_HI         2
`define NSDL_SEL_LO         0

// Legal direction register selectors
`define NSDL_SEL_MIN        3'h5
`define NSDL_SEL_MAX        3'h7

// Reset values
`define NSDL_W_RESET        8'h00
`define NSDL_DIR_RESET      8'hFF

`endif

// ==== rtl/nsdl_dir_reg.v ====
// One port direction register with two write paths and a read tap
`timescale 1ns/100ps
`include "nsdl_defs.vh"

module nsdl_dir_reg #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Write by direction-load instruction
  input  wire             ins_we,
  // Write by ordinary data-memory store
  input  wire             mem_we,
  input  wire [WIDTH-1:0] wdata,
  // Current value
  output reg  [WIDTH-1:0] value
);

  // All pins start as inputs; either write path loads the same data
  always @(posedge clk) begin
    if (!resetn) begin
      value <= `NSDL_DIR_RESET;
    end else if (ins_we || mem_we) begin
      value <= wdata;
    end
  end

endmodule

// ==== testbench/nsdl_asserts.sv ====
// Port checker for the nibble-exchange and direction-load block
`timescale 1ns/100ps
module nsdl_asserts (
  // Clock, reset, issue
  input wire       CLK,
  input wire       RESETN,
  input wire       INSTR_VALID,
  input wire [13:0] INSTR,
  input wire [7:0] FILE_RDATA,
  input wire [6:0] MEM_ADDR,
  // Results
  input wire       FILE_WE,
  input wire [6:0] FILE_WADDR,
  input wire [7:0] FILE_WDATA,
  input wire [7:0] W_VALUE,
  input wire       FLAGS_HOLD,
  input wire       DONE,
  input wire       ILLEGAL_SEL,
  input wire [7:0] DIR_B,
  input wire [7:0] MEM_RDATA,
  input wire       MEM_RHIT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Decoded issue of each instruction
  wire sw = INSTR_VALID && INSTR[13:8] == 6'h0E;
  wire dl = INSTR_VALID && INSTR[13:3] == 11'h00C;
  a_swap_to_w: assert property (sw && !INSTR[7] |=>
    DONE && FLAGS_HOLD && W_VALUE == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}) else $error("swap to W wrong");
  a_swap_to_f: assert property (sw && INSTR[7] |=>
    FILE_WE && FILE_WADDR == $past(INSTR[6:0]) && $stable(W_VALUE)) else $error("swap to file wrong");
  a_swap_data: assert property (sw |=> FILE_WDATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
    else $error("swapped data wrong");
  a_dir_load: assert property (dl && INSTR[2:0] == 3'h6 |-> ##2 DIR_B == $past(W_VALUE))
    else $error("direction load wrong");
  a_dir_refuse: assert property (dl && INSTR[2:0] < 3'h5 |=> ILLEGAL_SEL && !FILE_WE)
    else $error("bad selector not refused");
  a_dir_done: assert property (dl |=> DONE && FLAGS_HOLD && !FILE_WE)
    else $error("direction load not single cycle");
  a_mem_hit: assert property (MEM_ADDR == 7'h06 |=> MEM_RHIT) else $error("read-back miss");
  a_mem_miss: assert property (MEM_ADDR < 7'h05 |=> !MEM_RHIT && MEM_RDATA == 8'h00)
    else $error("false read-back hit");
endmodule
bind nsdl_core nsdl_asserts u_chk (.*);

// ==== testbench/nsdl_core_tb_top.sv ====
// Self-checking bench for the nibble-exchange and direction-load block
`timescale 1ns/100ps
module nsdl_core_tb_top;
  reg        CLK = 0, RESETN = 0, INSTR_VALID = 0, MEM_WE = 0;
  reg [13:0] INSTR = 14'h0000;
  reg [7:0]  FILE_RDATA = 8'h00, MEM_WDATA = 8'h00;
  reg [6:0]  MEM_ADDR = 7'h00;
  wire       FILE_WE, FLAGS_HOLD, DONE, ILLEGAL_SEL, MEM_RHIT;
  wire [6:0] FILE_WADDR;
  wire [7:0] FILE_WDATA, W_VALUE, DIR_A, DIR_B, DIR_C, MEM_RDATA;
  integer    failures = 0, total_checks = 0, k;
  nsdl_core uut (.*);
  initial forever #5 CLK = ~CLK;
  // Exact four-state compare
  task chk(input [7:0] s, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // One issue cycle; pulses are looked at just after the edge that follows the issue edge
  task op(input [13:0] i, input [7:0] r);
    begin
      @(posedge CLK) {INSTR_VALID, INSTR, FILE_RDATA} <= {1'b1, i, r};
      @(posedge CLK) INSTR_VALID <= 1'b0;
      #1;
    end
  endtask
  task t_swap;
    begin
      chk(DIR_C, 8'hFF);
      op(14'h0E05, 8'hA5);
      chk(W_VALUE, 8'h5A);
      chk({DONE, FLAGS_HOLD}, 8'h03);
      op(14'h0EFF, 8'h3C);
      chk(FILE_WDATA, 8'hC3);
      chk({FILE_WE, FILE_WADDR}, 8'hFF);
      chk(W_VALUE, 8'h5A);
      $display("test swap done");
    end
  endtask
  // Every selector; low ones must be refused
  task t_dir;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        op({11'h00C, k[2:0]}, 8'h00);
        chk(ILLEGAL_SEL, k < 5);
        chk({DONE, FLAGS_HOLD}, 8'h03);
      end
      @(posedge CLK) #1;
      chk(DIR_A, 8'h5A);
      chk(DIR_B, 8'h5A);
      chk(DIR_C, 8'h5A);
      $display("test direction load done");
    end
  endtask
  // Memory write lands two edges later; read-back lags one edge
  task t_mem;
    begin
      @(posedge CLK) {MEM_WE, MEM_ADDR, MEM_WDATA} <= {1'b1, 7'h05, 8'h11};
      @(posedge CLK) {MEM_WE, MEM_ADDR} <= {1'b0, 7'h06};
      @(posedge CLK) #1;
      chk(DIR_A, 8'h11);
      chk(MEM_RHIT, 8'h01);
      chk(MEM_RDATA, 8'h5A);
      @(posedge CLK) MEM_ADDR <= 7'h00;
      @(posedge CLK) #1;
      chk(MEM_RHIT, 8'h00);
      chk(MEM_RDATA, 8'h00);
      $display("test memory access done");
    end
  endtask
  // Load and store to sibling registers in one cycle, then a foreign opcode
  task t_mix;
    begin
      @(posedge CLK) begin
        {INSTR_VALID, INSTR} <= {1'b1, 11'h00C, 3'h5};
        {MEM_WE, MEM_ADDR, MEM_WDATA} <= {1'b1, 7'h06, 8'h22};
      end
      @(posedge CLK) {INSTR_VALID, INSTR, MEM_WE} <= {1'b1, 14'h0F05, 1'b0};
      @(posedge CLK) INSTR_VALID <= 1'b0;
      #1;
      chk({DONE, FLAGS_HOLD}, 8'h00);
      chk(W_VALUE, 8'h5A);
      chk(DIR_A, 8'h5A);
      chk(DIR_B, 8'h22);
      $display("test mixed writes done");
    end
  endtask
  // Mid-run reset returns every output to its reset value
  task t_reset;
    begin
      @(posedge CLK) {RESETN, MEM_ADDR} <= {1'b0, 7'h00};
      repeat (2) @(posedge CLK);
      #1;
      chk(DIR_B, 8'hFF);
      chk(W_VALUE, 8'h00);
      chk({FILE_WE, DONE, FLAGS_HOLD, ILLEGAL_SEL, MEM_RHIT}, 8'h00);
      chk(MEM_RDATA, 8'h00);
      @(posedge CLK) RESETN <= 1'b1;
      @(posedge CLK) #1;
      chk(DIR_A, 8'hFF);
      $display("test reset done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    t_swap;
    t_dir;
    t_mem;
    t_mix;
    t_reset;
    close_out;
  end
endmodule
